// *** core/ptb_params.svh ***
`ifndef PTB_PARAMS_SVH
`define PTB_PARAMS_SVH

// Counter and data widths
`define PTB_CW 16
`define PTB_NW 4
`define PTB_AW 12
`define PTB_DW 32

// Register byte offsets
`define PTB_CTRL_OFF 12'h000
`define PTB_TBDIV_OFF 12'h004
`define PTB_WPTL_OFF 12'h008
`define PTB_BTTL_OFF 12'h00C
`define PTB_BTTH_OFF 12'h010
`define PTB_BTN_OFF 12'h014
`define PTB_AGTL_OFF 12'h018
`define PTB_AGTH_OFF 12'h01C
`define PTB_STAT_OFF 12'h020
`define PTB_WPEL_OFF 12'h024
`define PTB_BTEL_OFF 12'h028
`define PTB_AGEL_OFF 12'h02C

// Control register fields
`define PTB_RET_WP 0
`define PTB_RET_BT 1
`define PTB_RET_AG 2
`define PTB_SRC_WPTL 3
`define PTB_SRC_BTTL 4
`define PTB_SRC_BTTH 5
`define PTB_SRC_AGTL 6
`define PTB_SRC_AGTH 7
`define PTB_CTRL_W 8

// Reset values
`define PTB_CTRL_RST 8'h00
`define PTB_TBDIV_RST 16'h0000
`define PTB_DUR_RST 16'h000A
`define PTB_N_RST 4'h1
`define PTB_N_MIN 4'h1
`define PTB_N_MAX 4'h9

`endif

// *** core/ptb_phase_tmr.sv ***
`timescale 1ns/10ps
`include "ptb_params.svh"

module ptb_phase_tmr
    import ptb_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic tick_i,
    input wire logic run_i,
    input wire logic clear_i,
    input wire logic lose_i,
    input wire logic phase_hi_i,
    input wire logic sel_lo_i,
    input wire logic sel_hi_i,
    input wire logic [`PTB_CW-1:0] lo_const_i,
    input wire logic [`PTB_CW-1:0] hi_const_i,
    input wire logic [`PTB_CW-1:0] lo_ext_i,
    input wire logic [`PTB_CW-1:0] hi_ext_i,
    output logic [`PTB_CW-1:0] elapsed_o,
    output logic expired_o
);

    logic [`PTB_CW-1:0] elapsed_reg;
    logic [`PTB_CW-1:0] elapsed_next;
    wire [`PTB_CW-1:0] dur_lo = sel_lo_i ? lo_ext_i : lo_const_i; // [RULE_11]
    wire [`PTB_CW-1:0] dur_hi = sel_hi_i ? hi_ext_i : hi_const_i; // [RULE_11]
    wire [`PTB_CW-1:0] dur = phase_hi_i ? dur_hi : dur_lo;
    wire expired = (elapsed_reg >= dur);
    wire advance = run_i & tick_i & ~expired; // [RULE_12]

    // Power loss without retention wipes the accumulated time
    assign elapsed_next = (clear_i | lose_i) ? '0 : // [RULE_10]
                          advance ? elapsed_reg + 1'b1 : elapsed_reg;

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            elapsed_reg <= '0;
        end else begin
            elapsed_reg <= elapsed_next;
        end
    end

    assign elapsed_o = elapsed_reg;
    assign expired_o = expired;

endmodule : ptb_phase_tmr

// *** core/ptb_pkg.sv ***
package ptb_pkg;

    typedef enum logic [2:0] {
        WP_IDLE = 3'b001,
        WP_PULSE = 3'b010,
        WP_HOLD = 3'b100
    } ptb_wp_state_t;

    typedef enum logic [2:0] {
        BT_IDLE = 3'b001,
        BT_LOW = 3'b010,
        BT_HIGH = 3'b100
    } ptb_bt_state_t;

    typedef enum logic [2:0] {
        AG_OFF = 3'b001,
        AG_HIGH = 3'b010,
        AG_LOW = 3'b100
    } ptb_ag_state_t;

endpackage : ptb_pkg

// *** core/ptb_timer_blocks.sv ***
// Overview of operation
// RULE_01: Pulse output rises on high trigger; elapsed time starts from zero.
// RULE_02: Pulse output clears when elapsed time reaches the low phase time.
// RULE_03: Pulse timer output clears at once when trigger falls early.
// RULE_04: Burst trigger rising edge starts low phase, then output high phase.
// RULE_05: Burst repeats the low-high cycle the set count, one to nine.
// RULE_06: New burst edge zeroes elapsed time and restarts the sequence.
// RULE_07: Burst wipe input forces output low and clears elapsed time.
// RULE_08: Enabled free-running generator alternates high and low phases.
// RULE_09: Polarity flip inverts free-running output only while enabled.
// RULE_10: Each block retains or clears output and elapsed time on power loss.
// RULE_11: Each duration comes from a constant or another block's live value.
// RULE_12: Timers step per tick; disabled generator stays low and cleared.
`timescale 1ns/10ps
`include "ptb_params.svh"

module ptb_timer_blocks
    import ptb_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`PTB_AW-1:0] paddr,
    input wire logic [`PTB_DW-1:0] pwdata,
    output logic [`PTB_DW-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic power_loss_i,
    input wire logic wp_trigger_i,
    input wire logic bt_trigger_i,
    input wire logic bt_wipe_i,
    input wire logic ag_enable_i,
    input wire logic ag_polarity_flip_i,
    input wire logic [`PTB_CW-1:0] wp_low_ext_i,
    input wire logic [`PTB_CW-1:0] bt_low_ext_i,
    input wire logic [`PTB_CW-1:0] bt_high_ext_i,
    input wire logic [`PTB_CW-1:0] ag_low_ext_i,
    input wire logic [`PTB_CW-1:0] ag_high_ext_i,
    output logic wp_pulse_o,
    output logic bt_pulse_o,
    output logic ag_pulse_o
);

    // Configuration registers
    logic [`PTB_CTRL_W-1:0] ctrl_reg;
    logic [`PTB_CW-1:0] tb_div_reg;
    logic [`PTB_CW-1:0] wp_low_reg;
    logic [`PTB_CW-1:0] bt_low_reg;
    logic [`PTB_CW-1:0] bt_high_reg;
    logic [`PTB_NW-1:0] bt_total_reg;
    logic [`PTB_CW-1:0] ag_low_reg;
    logic [`PTB_CW-1:0] ag_high_reg;
    logic [`PTB_DW-1:0] prdata_reg;

    // Timebase
    logic [`PTB_CW-1:0] tb_cnt_reg;
    logic [`PTB_CW-1:0] tb_cnt_next;

    // Block state
    ptb_wp_state_t wp_state_reg;
    ptb_wp_state_t wp_state_next;
    ptb_bt_state_t bt_state_reg;
    ptb_bt_state_t bt_state_next;
    ptb_ag_state_t ag_state_reg;
    ptb_ag_state_t ag_state_next;
    logic [`PTB_NW-1:0] bt_done_reg;
    logic [`PTB_NW-1:0] bt_done_next;
    logic bt_trig_prev_reg;
    logic wp_out_reg;
    logic wp_out_next;
    logic bt_out_reg;
    logic bt_out_next;
    logic ag_out_reg;
    logic ag_out_next;
    logic wp_clear;
    logic bt_clear;
    logic ag_clear;

    logic [`PTB_CW-1:0] wp_elapsed;
    logic [`PTB_CW-1:0] bt_elapsed;
    logic [`PTB_CW-1:0] ag_elapsed;
    logic wp_expired;
    logic bt_expired;
    logic ag_expired;

    // APB decode
    wire setup_ph = psel & ~penable;
    wire access_ph = psel & penable;
    wire wr_en = access_ph & pwrite;
    wire hit_ctrl = (paddr == `PTB_CTRL_OFF);
    wire hit_tbdiv = (paddr == `PTB_TBDIV_OFF);
    wire hit_wptl = (paddr == `PTB_WPTL_OFF);
    wire hit_bttl = (paddr == `PTB_BTTL_OFF);
    wire hit_btth = (paddr == `PTB_BTTH_OFF);
    wire hit_btn = (paddr == `PTB_BTN_OFF);
    wire hit_agtl = (paddr == `PTB_AGTL_OFF);
    wire hit_agth = (paddr == `PTB_AGTH_OFF);
    wire hit_stat = (paddr == `PTB_STAT_OFF);
    wire hit_wpel = (paddr == `PTB_WPEL_OFF);
    wire hit_btel = (paddr == `PTB_BTEL_OFF);
    wire hit_agel = (paddr == `PTB_AGEL_OFF);
    wire hit_any = hit_ctrl | hit_tbdiv | hit_wptl | hit_bttl | hit_btth |
                   hit_btn | hit_agtl | hit_agth | hit_stat | hit_wpel |
                   hit_btel | hit_agel;

    // Pulse count kept inside one through nine
    wire [`PTB_NW-1:0] n_wr = pwdata[`PTB_NW-1:0];
    wire [`PTB_NW-1:0] n_clamped = // [RULE_05]
        (n_wr < `PTB_N_MIN) ? `PTB_N_MIN :
        (n_wr > `PTB_N_MAX) ? `PTB_N_MAX : n_wr;

    wire [`PTB_DW-1:0] status_word = {{(`PTB_DW-`PTB_NW-4){1'b0}},
                                      bt_done_reg, 1'b0,
                                      ag_out_reg, bt_out_reg, wp_out_reg};

    wire [`PTB_DW-1:0] rd_mux =
        hit_ctrl ? {{(`PTB_DW-`PTB_CTRL_W){1'b0}}, ctrl_reg} :
        hit_tbdiv ? {{(`PTB_DW-`PTB_CW){1'b0}}, tb_div_reg} :
        hit_wptl ? {{(`PTB_DW-`PTB_CW){1'b0}}, wp_low_reg} :
        hit_bttl ? {{(`PTB_DW-`PTB_CW){1'b0}}, bt_low_reg} :
        hit_btth ? {{(`PTB_DW-`PTB_CW){1'b0}}, bt_high_reg} :
        hit_btn ? {{(`PTB_DW-`PTB_NW){1'b0}}, bt_total_reg} :
        hit_agtl ? {{(`PTB_DW-`PTB_CW){1'b0}}, ag_low_reg} :
        hit_agth ? {{(`PTB_DW-`PTB_CW){1'b0}}, ag_high_reg} :
        hit_stat ? status_word :
        hit_wpel ? {{(`PTB_DW-`PTB_CW){1'b0}}, wp_elapsed} :
        hit_btel ? {{(`PTB_DW-`PTB_CW){1'b0}}, bt_elapsed} :
        hit_agel ? {{(`PTB_DW-`PTB_CW){1'b0}}, ag_elapsed} :
        '0;

    assign pready = 1'b1;
    assign pslverr = access_ph & ~hit_any;
    assign prdata = prdata_reg;

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            prdata_reg <= '0;
        end else if (setup_ph) begin
            prdata_reg <= rd_mux;
        end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctrl_reg <= `PTB_CTRL_RST;
            tb_div_reg <= `PTB_TBDIV_RST;
            wp_low_reg <= `PTB_DUR_RST;
            bt_low_reg <= `PTB_DUR_RST;
            bt_high_reg <= `PTB_DUR_RST;
            bt_total_reg <= `PTB_N_RST;
            ag_low_reg <= `PTB_DUR_RST;
            ag_high_reg <= `PTB_DUR_RST;
        end else if (wr_en) begin
            if (hit_ctrl) ctrl_reg <= pwdata[`PTB_CTRL_W-1:0];
            if (hit_tbdiv) tb_div_reg <= pwdata[`PTB_CW-1:0];
            if (hit_wptl) wp_low_reg <= pwdata[`PTB_CW-1:0];
            if (hit_bttl) bt_low_reg <= pwdata[`PTB_CW-1:0];
            if (hit_btth) bt_high_reg <= pwdata[`PTB_CW-1:0];
            if (hit_btn) bt_total_reg <= n_clamped;
            if (hit_agtl) ag_low_reg <= pwdata[`PTB_CW-1:0];
            if (hit_agth) ag_high_reg <= pwdata[`PTB_CW-1:0];
        end
    end

    // Common timebase tick
    wire tick = (tb_cnt_reg >= tb_div_reg); // [RULE_12]
    assign tb_cnt_next = tick ? '0 : tb_cnt_reg + 1'b1;

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tb_cnt_reg <= '0;
        end else begin
            tb_cnt_reg <= tb_cnt_next;
        end
    end

    // Power loss handling per block
    wire wp_lose = power_loss_i & ~ctrl_reg[`PTB_RET_WP]; // [RULE_10]
    wire bt_lose = power_loss_i & ~ctrl_reg[`PTB_RET_BT]; // [RULE_10]
    wire ag_lose = power_loss_i & ~ctrl_reg[`PTB_RET_AG]; // [RULE_10]

    // Single pulse timer
    always_comb begin
        wp_state_next = wp_state_reg;
        wp_out_next = wp_out_reg;
        wp_clear = 1'b0;
        case (wp_state_reg)
            WP_IDLE: begin
                if (wp_trigger_i) begin
                    wp_state_next = WP_PULSE;
                    wp_out_next = 1'b1; // [RULE_01]
                    wp_clear = 1'b1; // [RULE_01]
                end
            end
            WP_PULSE: begin
                if (!wp_trigger_i) begin
                    wp_state_next = WP_IDLE;
                    wp_out_next = 1'b0; // [RULE_03]
                end else if (wp_expired) begin
                    wp_state_next = WP_HOLD;
                    wp_out_next = 1'b0; // [RULE_02]
                end
            end
            WP_HOLD: begin
                if (!wp_trigger_i) begin
                    wp_state_next = WP_IDLE;
                end
            end
            default: begin
                wp_state_next = WP_IDLE;
                wp_out_next = 1'b0;
            end
        endcase
        if (wp_lose) begin
            wp_state_next = WP_HOLD; // [RULE_10]
            wp_out_next = 1'b0; // [RULE_10]
        end
    end

    // Burst generator
    wire bt_edge = bt_trigger_i & ~bt_trig_prev_reg; // [RULE_04]
    wire [`PTB_NW-1:0] bt_done_inc = bt_done_reg + 1'b1;

    always_comb begin
        bt_state_next = bt_state_reg;
        bt_out_next = bt_out_reg;
        bt_done_next = bt_done_reg;
        bt_clear = 1'b0;
        case (bt_state_reg)
            BT_IDLE: begin
                bt_out_next = 1'b0;
            end
            BT_LOW: begin
                if (bt_expired) begin
                    bt_state_next = BT_HIGH;
                    bt_out_next = 1'b1; // [RULE_04]
                    bt_clear = 1'b1;
                end
            end
            BT_HIGH: begin
                if (bt_expired) begin
                    bt_out_next = 1'b0;
                    bt_clear = 1'b1;
                    bt_done_next = bt_done_inc;
                    if (bt_done_inc >= bt_total_reg) begin // [RULE_05]
                        bt_state_next = BT_IDLE;
                    end else begin
                        bt_state_next = BT_LOW; // [RULE_05]
                    end
                end
            end
            default: begin
                bt_state_next = BT_IDLE;
                bt_out_next = 1'b0;
            end
        endcase
        if (bt_edge) begin
            bt_state_next = BT_LOW; // [RULE_04] [RULE_06]
            bt_out_next = 1'b0;
            bt_done_next = '0;
            bt_clear = 1'b1; // [RULE_06]
        end
        if (bt_wipe_i | bt_lose) begin
            bt_state_next = BT_IDLE; // [RULE_07] [RULE_10]
            bt_out_next = 1'b0; // [RULE_07]
            bt_done_next = '0;
            bt_clear = 1'b1; // [RULE_07]
        end
    end

    // Free-running asymmetric generator
    always_comb begin
        ag_state_next = ag_state_reg;
        ag_clear = 1'b0;
        case (ag_state_reg)
            AG_OFF: begin
                ag_clear = 1'b1;
                if (ag_enable_i) begin
                    ag_state_next = AG_HIGH;
                end
            end
            AG_HIGH: begin
                if (ag_expired) begin
                    ag_state_next = AG_LOW; // [RULE_08]
                    ag_clear = 1'b1;
                end
            end
            AG_LOW: begin
                if (ag_expired) begin
                    ag_state_next = AG_HIGH; // [RULE_08]
                    ag_clear = 1'b1;
                end
            end
            default: begin
                ag_state_next = AG_OFF;
                ag_clear = 1'b1;
            end
        endcase
        if (!ag_enable_i | ag_lose) begin
            ag_state_next = AG_OFF; // [RULE_12] [RULE_10]
            ag_clear = 1'b1; // [RULE_12]
        end
        // Inversion only acts on a running generator
        if (ag_state_next == AG_OFF) begin
            ag_out_next = 1'b0; // [RULE_09] [RULE_12]
        end else begin
            ag_out_next = (ag_state_next == AG_HIGH) ^
                          ag_polarity_flip_i; // [RULE_09]
        end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wp_state_reg <= WP_IDLE;
            bt_state_reg <= BT_IDLE;
            ag_state_reg <= AG_OFF;
            bt_done_reg <= '0;
            bt_trig_prev_reg <= 1'b0;
            wp_out_reg <= 1'b0;
            bt_out_reg <= 1'b0;
            ag_out_reg <= 1'b0;
        end else begin
            wp_state_reg <= wp_state_next;
            bt_state_reg <= bt_state_next;
            ag_state_reg <= ag_state_next;
            bt_done_reg <= bt_done_next;
            bt_trig_prev_reg <= bt_trigger_i;
            wp_out_reg <= wp_out_next;
            bt_out_reg <= bt_out_next;
            ag_out_reg <= ag_out_next;
        end
    end

    assign wp_pulse_o = wp_out_reg;
    assign bt_pulse_o = bt_out_reg;
    assign ag_pulse_o = ag_out_reg;

    // Phase timers
    ptb_phase_tmr u_wp_tmr (
        .core_clk_i(core_clk_i),
        .rstn_i(rstn_i),
        .tick_i(tick),
        .run_i(wp_state_reg == WP_PULSE),
        .clear_i(wp_clear),
        .lose_i(wp_lose),
        .phase_hi_i(1'b0),
        .sel_lo_i(ctrl_reg[`PTB_SRC_WPTL]),
        .sel_hi_i(ctrl_reg[`PTB_SRC_WPTL]),
        .lo_const_i(wp_low_reg),
        .hi_const_i(wp_low_reg),
        .lo_ext_i(wp_low_ext_i),
        .hi_ext_i(wp_low_ext_i),
        .elapsed_o(wp_elapsed),
        .expired_o(wp_expired)
    );

    ptb_phase_tmr u_bt_tmr (
        .core_clk_i(core_clk_i),
        .rstn_i(rstn_i),
        .tick_i(tick),
        .run_i(bt_state_reg != BT_IDLE),
        .clear_i(bt_clear),
        .lose_i(bt_lose),
        .phase_hi_i(bt_state_reg == BT_HIGH),
        .sel_lo_i(ctrl_reg[`PTB_SRC_BTTL]),
        .sel_hi_i(ctrl_reg[`PTB_SRC_BTTH]),
        .lo_const_i(bt_low_reg),
        .hi_const_i(bt_high_reg),
        .lo_ext_i(bt_low_ext_i),
        .hi_ext_i(bt_high_ext_i),
        .elapsed_o(bt_elapsed),
        .expired_o(bt_expired)
    );

    ptb_phase_tmr u_ag_tmr (
        .core_clk_i(core_clk_i),
        .rstn_i(rstn_i),
        .tick_i(tick),
        .run_i(ag_state_reg != AG_OFF),
        .clear_i(ag_clear),
        .lose_i(ag_lose),
        .phase_hi_i(ag_state_reg == AG_HIGH),
        .sel_lo_i(ctrl_reg[`PTB_SRC_AGTL]),
        .sel_hi_i(ctrl_reg[`PTB_SRC_AGTH]),
        .lo_const_i(ag_low_reg),
        .hi_const_i(ag_high_reg),
        .lo_ext_i(ag_low_ext_i),
        .hi_ext_i(ag_high_ext_i),
        .elapsed_o(ag_elapsed),
        .expired_o(ag_expired)
    );

endmodule : ptb_timer_blocks

// *** dv/ptb_src_model.sv ***
`timescale 1ns/10ps
`include "ptb_params.svh"
module ptb_src_model
    import ptb_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic load_i,
    input wire logic [`PTB_CW-1:0] val_i,
    output logic [`PTB_CW-1:0] value_o
);
    logic [`PTB_CW-1:0] value_reg;
    // Live value of a neighbouring block, loadable at run time
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            value_reg <= 16'h0001;
        end else if (load_i) begin
            value_reg <= val_i;
        end
    end
    assign value_o = value_reg;
endmodule : ptb_src_model

// *** dv/ptb_timer_blocks_sva.sv ***
`timescale 1ns/10ps
module ptb_chk_sva
    import ptb_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic psel,
    input wire logic penable,
    input wire logic pslverr,
    input wire logic power_loss_i,
    input wire logic wp_trigger_i,
    input wire logic bt_trigger_i,
    input wire logic bt_wipe_i,
    input wire logic ag_enable_i,
    input wire logic ag_polarity_flip_i,
    input wire logic wp_pulse_o,
    input wire logic bt_pulse_o,
    input wire logic ag_pulse_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);
    sequence s_wp_fire;
        (!wp_trigger_i && !power_loss_i) ##1
            (wp_trigger_i && !power_loss_i);
    endsequence
    sequence s_bt_edge;
        !bt_trigger_i ##1 bt_trigger_i;
    endsequence
    sequence s_ag_on;
        !ag_enable_i ##1 (ag_enable_i && !power_loss_i);
    endsequence
    a_wp_trig_low: assert property (!wp_trigger_i |=> !wp_pulse_o)
        else $error("pulse timer output high after trigger low");
    a_wp_fire: assert property (s_wp_fire |=> wp_pulse_o)
        else $error("pulse timer did not fire on trigger");
    a_bt_wipe_low: assert property (bt_wipe_i |=> !bt_pulse_o)
        else $error("burst output high after wipe");
    a_bt_low_first: assert property (s_bt_edge |=> !bt_pulse_o)
        else $error("burst did not start with low phase");
    a_bt_rise_cause: assert property ($rose(bt_pulse_o) |->
        !$past(bt_wipe_i))
        else $error("burst output rose during wipe");
    a_ag_off_low: assert property (!ag_enable_i |=>
        !ag_pulse_o)
        else $error("free-running output high while disabled");
    a_ag_start_hi: assert property (s_ag_on |=>
        (ag_pulse_o != $past(ag_polarity_flip_i)))
        else $error("free-running start level wrong");
    a_apb_err_phase: assert property (pslverr |-> psel && penable)
        else $error("slave error outside access phase");
endmodule : ptb_chk_sva

bind ptb_timer_blocks ptb_chk_sva ptb_chk_sva_inst (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .psel(psel),
    .penable(penable),
    .pslverr(pslverr),
    .power_loss_i(power_loss_i),
    .wp_trigger_i(wp_trigger_i),
    .bt_trigger_i(bt_trigger_i),
    .bt_wipe_i(bt_wipe_i),
    .ag_enable_i(ag_enable_i),
    .ag_polarity_flip_i(ag_polarity_flip_i),
    .wp_pulse_o(wp_pulse_o),
    .bt_pulse_o(bt_pulse_o),
    .ag_pulse_o(ag_pulse_o)
);

// *** dv/tb.sv ***
`timescale 1ns/10ps
`include "ptb_params.svh"
module tb
    import ptb_pkg::*;
;
    logic core_clk_i, rstn_i, psel, penable, pwrite, pready, pslverr, err;
    logic [`PTB_AW-1:0] paddr;
    logic [`PTB_DW-1:0] pwdata, prdata, rd;
    logic power_loss_i, wp_trg, bt_trg, bt_wipe, ag_en, ag_flip, src_load;
    logic [`PTB_CW-1:0] src_val, ext;
    logic [2:0] outs;
    int bad_count, compares, cyc, n, m;
    initial begin
        core_clk_i = 1'b0;
        forever #20 core_clk_i = ~core_clk_i;
    end
    ptb_src_model ptb_src_model_inst (.core_clk_i(core_clk_i),
        .rstn_i(rstn_i), .load_i(src_load), .val_i(src_val),
        .value_o(ext));
    ptb_timer_blocks ptb_timer_blocks_inst (.core_clk_i(core_clk_i),
        .rstn_i(rstn_i), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .power_loss_i(power_loss_i),
        .wp_trigger_i(wp_trg), .bt_trigger_i(bt_trg), .bt_wipe_i(bt_wipe),
        .ag_enable_i(ag_en), .ag_polarity_flip_i(ag_flip),
        .wp_low_ext_i(ext), .bt_low_ext_i(ext), .bt_high_ext_i(ext),
        .ag_low_ext_i(ext), .ag_high_ext_i(ext), .wp_pulse_o(outs[0]),
        .bt_pulse_o(outs[1]), .ag_pulse_o(outs[2]));
    task automatic finish_test();
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : finish_test
    always @(posedge core_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            finish_test();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int k);
        repeat (k) @(posedge core_clk_i);
    endtask : tick
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge core_clk_i);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk_i);
        penable <= 1'b1;
        @(posedge core_clk_i);
        while (pready !== 1'b1) begin
            @(posedge core_clk_i);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic watch(input int k, input int len, output int hi,
                         output int rs);
        logic prev;
        hi = 0;
        rs = 0;
        prev = 1'b0;
        repeat (len) begin
            @(negedge core_clk_i);
            if (outs[k] === 1'b1) begin
                hi++;
                if (prev !== 1'b1) rs++;
            end
            prev = outs[k];
        end
        @(posedge core_clk_i);
    endtask : watch
    task automatic run_len(input int k, input logic lvl, output int len);
        len = 0;
        @(negedge core_clk_i);
        // Skip a run already under way, then measure a whole one
        while (outs[k] === lvl) begin
            @(negedge core_clk_i);
        end
        while (outs[k] !== lvl) begin
            @(negedge core_clk_i);
        end
        while (outs[k] === lvl && len < 200) begin
            len++;
            @(negedge core_clk_i);
        end
        @(posedge core_clk_i);
    endtask : run_len
    task automatic wp_fire(input int exp_hi);
        fork
            watch(0, 40, n, m);
            begin
                @(posedge core_clk_i);
                wp_trg <= 1'b1;
            end
        join
        chk(32'(n), 32'(exp_hi));
        wp_trg <= 1'b0;
        tick(2);
    endtask : wp_fire
    initial begin
        {psel, penable, pwrite, power_loss_i, src_load} = 5'h00;
        {wp_trg, bt_trg, bt_wipe, ag_en, ag_flip} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        src_val = 16'h0000;
        rstn_i = 1'b0;
        bad_count = 0;
        compares = 0;
        cyc = 0;
        tick(4);
        rstn_i <= 1'b1;
        apb(1'b0, `PTB_CTRL_OFF, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, `PTB_WPTL_OFF, 32'h0);
        chk(rd, 32'h0000000A);
        apb(1'b0, 12'h030, 32'h0);
        chk({rd[30:0], err}, 32'h1);
        apb(1'b1, `PTB_BTN_OFF, 32'h0);
        apb(1'b0, `PTB_BTN_OFF, 32'h0);
        chk(rd, 32'h1);
        apb(1'b1, `PTB_BTN_OFF, 32'h0000000F);
        apb(1'b0, `PTB_BTN_OFF, 32'h0);
        chk(rd, 32'h9);
        apb(1'b1, `PTB_WPTL_OFF, 32'h3);
        wp_fire(4);
        fork
            watch(0, 12, n, m);
            begin
                @(posedge core_clk_i);
                wp_trg <= 1'b1;
                tick(2);
                wp_trg <= 1'b0;
            end
        join
        chk(32'(n), 32'h2);
        apb(1'b1, `PTB_CTRL_OFF, 32'h00000009);
        for (int v = 2; v <= 5; v += 3) begin
            @(posedge core_clk_i);
            src_load <= 1'b1;
            src_val <= 16'(v);
            @(posedge core_clk_i);
            src_load <= 1'b0;
            wp_fire(v + 1);
        end
        for (int r = 0; r < 2; r++) begin
            apb(1'b1, `PTB_CTRL_OFF, 32'(r));
            apb(1'b1, `PTB_WPTL_OFF, 32'h14);
            @(posedge core_clk_i);
            wp_trg <= 1'b1;
            tick(3);
            power_loss_i <= 1'b1;
            tick(1);
            power_loss_i <= 1'b0;
            @(negedge core_clk_i);
            chk({31'h0, outs[0]}, 32'(r));
            @(posedge core_clk_i);
            wp_trg <= 1'b0;
            tick(2);
        end
        apb(1'b1, `PTB_TBDIV_OFF, 32'h1);
        apb(1'b1, `PTB_WPTL_OFF, 32'h3);
        fork
            watch(0, 20, n, m);
            begin
                @(posedge core_clk_i);
                wp_trg <= 1'b1;
            end
        join
        // Tick every second cycle: high for twice the duration, give or take
        chk(32'(n / 2), 32'h3);
        wp_trg <= 1'b0;
        apb(1'b1, `PTB_TBDIV_OFF, 32'h0);
        apb(1'b1, `PTB_BTTL_OFF, 32'h2);
        apb(1'b1, `PTB_BTTH_OFF, 32'h3);
        for (int k = 1; k <= 9; k += 8) begin
            apb(1'b1, `PTB_BTN_OFF, 32'(k));
            fork
                watch(1, 90, n, m);
                begin
                    @(posedge core_clk_i);
                    bt_trg <= 1'b1;
                end
            join
            chk(32'(m), 32'(k));
            chk(32'(n), 32'(4 * k));
            bt_trg <= 1'b0;
        end
        apb(1'b1, `PTB_BTN_OFF, 32'h3);
        fork
            watch(1, 60, n, m);
            begin
                @(posedge core_clk_i);
                bt_trg <= 1'b1;
                tick(5);
                bt_trg <= 1'b0;
                tick(1);
                bt_trg <= 1'b1;
            end
        join
        chk(32'(m), 32'h4);
        bt_trg <= 1'b0;
        fork
            watch(1, 30, n, m);
            begin
                @(posedge core_clk_i);
                bt_trg <= 1'b1;
                tick(6);
                bt_wipe <= 1'b1;
                tick(1);
                bt_wipe <= 1'b0;
            end
        join
        chk(32'(m), 32'h1);
        apb(1'b0, `PTB_BTEL_OFF, 32'h0);
        chk(rd, 32'h0);
        bt_trg <= 1'b0;
        apb(1'b1, `PTB_AGTH_OFF, 32'h3);
        apb(1'b1, `PTB_AGTL_OFF, 32'h2);
        ag_en <= 1'b1;
        run_len(2, 1'b1, n);
        chk(32'(n), 32'h4);
        run_len(2, 1'b0, n);
        chk(32'(n), 32'h3);
        ag_en <= 1'b0;
        tick(2);
        ag_flip <= 1'b1;
        watch(2, 10, n, m);
        chk(32'(n), 32'h0);
        @(posedge core_clk_i);
        ag_en <= 1'b1;
        run_len(2, 1'b1, n);
        chk(32'(n), 32'h3);
        ag_en <= 1'b0;
        ag_flip <= 1'b0;
        tick(4);
        finish_test();
    end
endmodule : tb
